// ==== inc/rtc_pkg.sv ====
// constants, field layout and types shared by the counter and backup store
// Overview of operation
// - forty-two sixteen-bit backup words, 84 bytes
// - backup words survive every reset and wake-up
// - counter clock: slow crystal, low-power oscillator, fast/128
// - drive a 512 Hz calibration clock out
// - software-loadable 32-bit main counter
// - run never clears once set, but the spare source code still stops the counter
// - alarm when counter matches compare register
// - 20-bit prescaler divides selected counter clock
// - prescaler resets to one-second tick at 32.768 kHz
// - alarm and periodic interrupt requests
package rtc_pkg;
    localparam int ADDR_W = 8;
    localparam int CNT_W = 32;
    localparam int PRESC_W = 20;
    localparam int BKP_W = 16;
    localparam int BKP_WORDS = 42;
    localparam int BKP_AW = 6;

    // register byte offsets
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_IRQ_EN = 8'h08;
    localparam logic [ADDR_W-1:0] REG_IRQ_CLR = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_RELOAD = 8'h10;
    localparam logic [ADDR_W-1:0] REG_DIVIDER = 8'h14;
    localparam logic [ADDR_W-1:0] REG_COUNT = 8'h18;
    localparam logic [ADDR_W-1:0] REG_COMPARE = 8'h1c;
    localparam logic [ADDR_W-1:0] REG_BACKUP = 8'h40;

    // control and status fields
    localparam int CTRL_SRC_LSB = 0;
    localparam int CTRL_RUN_BIT = 2;
    localparam int CTRL_CAL_BIT = 3;
    localparam int STAT_ALARM_BIT = 0;
    localparam int STAT_TICK_BIT = 1;

    // reset values and divider figures
    localparam logic [PRESC_W-1:0] RELOAD_RST = 20'h07fff;
    localparam int HSE_DIV = 128;
    localparam int HSE_DIV_W = 7;
    localparam int CAL_HALF = 32;
    localparam int CAL_W = 5;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        SRC_LSE = 2'b00,
        SRC_LSI = 2'b01,
        SRC_HSE = 2'b10,
        SRC_OFF = 2'b11
    } src_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_FETCH = 2'b01,
        RD_RESP = 2'b10
    } rd_state_t;
endpackage : rtc_pkg

// ==== verilog/rtc_backup_mem.sv ====
// retained backup word store with byte enables and registered read
`timescale 1ns/100ps
module rtc_backup_mem
    import rtc_pkg::*;
#(
    parameter int DEPTH = BKP_WORDS,
    parameter int WIDTH = BKP_W,
    parameter int AW = BKP_AW
) (
    input wire logic aclk,
    input wire logic wr_en,
    input wire logic [1:0] wr_be,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    if (DEPTH > (1 << AW) || WIDTH != 16) begin : g_bad
        $error("backup store: depth exceeds address range or width is not 16");
    end

    // no reset on purpose: contents outlive every reset
    always_ff @(posedge aclk) begin
        if (wr_en && wr_addr < AW'(DEPTH)) begin
            if (wr_be[0]) mem[wr_addr][7:0] <= wr_data[7:0];
            if (wr_be[1]) mem[wr_addr][15:8] <= wr_data[15:8];
        end
    end

    // out-of-range reads return zero rather than an unknown word
    always_ff @(posedge aclk) begin
        if (rd_addr < AW'(DEPTH)) begin
            rd_data <= mem[rd_addr];
        end else begin
            rd_data <= '0;
        end
    end
endmodule : rtc_backup_mem

// ==== verilog/rtc_clk_select.sv ====
// slow clock pin synchronisers, fast clock divider and source select
`timescale 1ns/100ps
module rtc_clk_select
    import rtc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic lse_pin,
    input wire logic lsi_pin,
    input wire logic hse_pin,
    input wire logic [1:0] src_sel,
    output logic slow_tick
);
    logic [2:0] pins;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] prev;
    logic [2:0] rise;
    logic [HSE_DIV_W-1:0] hse_cnt;
    logic hse_tick;

    assign pins = {hse_pin, lsi_pin, lse_pin};

    // two flops per pin, then a third for rising-edge detection
    for (genvar i = 0; i < 3; i++) begin : g_sync
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                sync1[i] <= 1'b0;
                sync2[i] <= 1'b0;
                prev[i] <= 1'b0;
            end else begin
                sync1[i] <= pins[i];
                sync2[i] <= sync1[i];
                prev[i] <= sync2[i];
            end
        end
        assign rise[i] = sync2[i] & ~prev[i];
    end

    // fast clock divided by 128 on its own edges
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hse_cnt <= '0;
        end else if (rise[2]) begin
            hse_cnt <= hse_cnt + 1'b1;
        end
    end
    assign hse_tick = rise[2] && (hse_cnt == HSE_DIV_W'(HSE_DIV - 1));

    // one pulse per edge of the chosen slow source, or per 128 fast clock edges; the spare code stops it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slow_tick <= 1'b0;
        end else begin
            case (src_sel)
                SRC_LSE: slow_tick <= rise[0];
                SRC_LSI: slow_tick <= rise[1];
                SRC_HSE: slow_tick <= hse_tick;
                default: slow_tick <= 1'b0;
            endcase
        end
    end

    src_pick_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (src_sel == SRC_LSE && $past(src_sel) == SRC_LSE) |-> slow_tick == $past(rise[0]))
        else $error("slow tick does not follow the selected slow crystal edge");
endmodule : rtc_clk_select

// ==== verilog/rtc_core.sv ====
// real-time counter, alarm, calibration output and backup store behind an axi4-lite slave
`timescale 1ns/100ps
module rtc_core
    import rtc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic lse_pin,
    input wire logic lsi_pin,
    input wire logic hse_pin,
    output logic cal_out,
    output logic alarm_irq,
    output logic tick_irq,
    output logic irq
);
    localparam logic [5:0] BKP_BASE_WORD = REG_BACKUP[7:2];

    if (int'(REG_BACKUP) + BKP_WORDS * 4 > (1 << ADDR_W)) begin : g_bad
        $error("backup words do not fit in the register window");
    end

    // write channel holding state
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr_q;
    logic w_held;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic do_wr;
    // read channel state
    rd_state_t rd_state;
    logic [ADDR_W-1:0] ar_addr_q;
    // control and timekeeping
    logic [1:0] src_sel;
    logic run;
    logic cal_en;
    logic [1:0] status;
    logic [1:0] irq_en;
    logic [PRESC_W-1:0] reload;
    logic [PRESC_W-1:0] divider;
    logic [CNT_W-1:0] counter;
    logic [CNT_W-1:0] compare;
    logic [CAL_W-1:0] cal_cnt;
    logic slow_tick;
    logic presc_tick;
    logic cnt_upd;
    logic alarm_ev;
    // decoded writes
    logic wr_ctrl;
    logic wr_irq_en;
    logic wr_irq_clr;
    logic wr_reload;
    logic wr_count;
    logic wr_compare;
    logic wr_bkp;
    logic wr_hit;
    logic [1:0] clr_mask;
    logic [31:0] next_reload_w;
    logic [31:0] next_count;
    logic [31:0] next_compare;
    // backup store access
    logic [5:0] wr_word;
    logic [5:0] rd_word;
    logic [5:0] q_word;
    logic [BKP_AW-1:0] bkp_wr_idx;
    logic [BKP_AW-1:0] bkp_rd_idx;
    logic [BKP_W-1:0] bkp_rdata;
    logic rd_bkp_hit;

    // merge a written word into an old value under byte strobes
    function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) res[i*8 +: 8] = new_v[i*8 +: 8];
        end
        return res;
    endfunction : apply_strb

    // true when a word index lands inside the backup window
    function automatic logic in_bkp(input logic [5:0] word);
        return (word >= BKP_BASE_WORD) && (word < BKP_BASE_WORD + 6'(BKP_WORDS));
    endfunction : in_bkp

    rtc_clk_select u_clk_select (
        .aclk(aclk),
        .aresetn(aresetn),
        .lse_pin(lse_pin),
        .lsi_pin(lsi_pin),
        .hse_pin(hse_pin),
        .src_sel(src_sel),
        .slow_tick(slow_tick)
    );

    rtc_backup_mem u_backup (
        .aclk(aclk),
        .wr_en(wr_bkp),
        .wr_be(w_strb_q[1:0]),
        .wr_addr(bkp_wr_idx),
        .wr_data(w_data_q[BKP_W-1:0]),
        .rd_addr(bkp_rd_idx),
        .rd_data(bkp_rdata)
    );

    // ---- write path: address and data taken in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign do_wr = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (do_wr) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (do_wr) begin
            w_held <= 1'b0;
        end
    end

    // address decode of the held write
    assign wr_word = aw_addr_q[7:2];
    assign wr_ctrl = do_wr && aw_addr_q == REG_CTRL;
    assign wr_irq_en = do_wr && aw_addr_q == REG_IRQ_EN;
    assign wr_irq_clr = do_wr && aw_addr_q == REG_IRQ_CLR;
    assign wr_reload = do_wr && aw_addr_q == REG_RELOAD;
    assign wr_count = do_wr && aw_addr_q == REG_COUNT;
    assign wr_compare = do_wr && aw_addr_q == REG_COMPARE;
    assign wr_bkp = do_wr && in_bkp(wr_word);
    assign bkp_wr_idx = BKP_AW'(wr_word - BKP_BASE_WORD);
    // read-only registers accept the write and ignore it
    assign wr_hit = wr_ctrl || wr_irq_en || wr_irq_clr || wr_reload || wr_count
        || wr_compare || wr_bkp || aw_addr_q == REG_STATUS || aw_addr_q == REG_DIVIDER;
    assign clr_mask = wr_irq_clr && w_strb_q[0] ? w_data_q[1:0] : 2'h0;
    assign next_reload_w = apply_strb({12'h000, reload}, w_data_q, w_strb_q);
    assign next_count = apply_strb(counter, w_data_q, w_strb_q);
    assign next_compare = apply_strb(compare, w_data_q, w_strb_q);

    // write response, one cycle after both halves are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_DECERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ---- read path: the store is addressed straight from araddr so its
    // registered word is ready in the fetch cycle
    assign s_axi_arready = rd_state == RD_IDLE;
    assign rd_word = s_axi_araddr[7:2];
    assign bkp_rd_idx = BKP_AW'(rd_word - BKP_BASE_WORD);
    assign q_word = ar_addr_q[7:2];
    assign rd_bkp_hit = in_bkp(q_word);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state <= RD_IDLE;
            ar_addr_q <= '0;
        end else begin
            case (rd_state)
                RD_IDLE: begin
                    if (s_axi_arvalid) begin
                        ar_addr_q <= s_axi_araddr;
                        rd_state <= RD_FETCH;
                    end
                end
                RD_FETCH: rd_state <= RD_RESP;
                RD_RESP: begin
                    if (s_axi_rready) rd_state <= RD_IDLE;
                end
                default: rd_state <= RD_IDLE;
            endcase
        end
    end

    // read data mux, captured at the end of the fetch cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (rd_state == RD_FETCH) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            case (ar_addr_q)
                REG_CTRL: s_axi_rdata <= {28'h0000000, cal_en, run, src_sel};
                REG_STATUS: s_axi_rdata <= {30'h00000000, status};
                REG_IRQ_EN: s_axi_rdata <= {30'h00000000, irq_en};
                REG_IRQ_CLR: s_axi_rdata <= '0;
                REG_RELOAD: s_axi_rdata <= {12'h000, reload};
                REG_DIVIDER: s_axi_rdata <= {12'h000, divider};
                REG_COUNT: s_axi_rdata <= counter;
                REG_COMPARE: s_axi_rdata <= compare;
                default: begin
                    s_axi_rdata <= rd_bkp_hit ? {16'h0000, bkp_rdata} : 32'h00000000;
                    s_axi_rresp <= rd_bkp_hit ? RESP_OKAY : RESP_DECERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // control: run can only be set; the time base still halts when src_sel picks the spare code
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_sel <= SRC_LSE;
            run <= 1'b0;
            cal_en <= 1'b0;
        end else if (wr_ctrl && w_strb_q[0]) begin
            src_sel <= w_data_q[CTRL_SRC_LSB +: 2];
            run <= run | w_data_q[CTRL_RUN_BIT];
            cal_en <= w_data_q[CTRL_CAL_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_en <= 2'h0;
        end else if (wr_irq_en && w_strb_q[0]) begin
            irq_en <= w_data_q[1:0];
        end
    end

    // ---- prescaler: reload defaults to a one-second tick from 32.768 kHz
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reload <= RELOAD_RST;
        end else if (wr_reload) begin
            reload <= next_reload_w[PRESC_W-1:0];
        end
    end

    // counts down on source edges; a reload write restarts the period
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            divider <= RELOAD_RST;
        end else if (wr_reload) begin
            divider <= next_reload_w[PRESC_W-1:0];
        end else if (run && slow_tick) begin
            divider <= divider == '0 ? reload : divider - 1'b1;
        end
    end
    assign presc_tick = run && slow_tick && divider == '0 && !wr_reload;

    // ---- main counter: a load wins over a tick in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            counter <= '0;
            cnt_upd <= 1'b0;
        end else begin
            cnt_upd <= wr_count || presc_tick;
            if (wr_count) begin
                counter <= next_count;
            end else if (presc_tick) begin
                counter <= counter + 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            compare <= '0;
        end else if (wr_compare) begin
            compare <= next_compare;
        end
    end

    // equality is judged once per counter change, so a stopped match
    // does not keep re-arming the flag after software clears it
    assign alarm_ev = cnt_upd && counter == compare;

    // sticky flags; a new event beats a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status <= 2'h0;
        end else begin
            status[STAT_ALARM_BIT] <= alarm_ev
                | (status[STAT_ALARM_BIT] & ~clr_mask[STAT_ALARM_BIT]);
            status[STAT_TICK_BIT] <= presc_tick
                | (status[STAT_TICK_BIT] & ~clr_mask[STAT_TICK_BIT]);
        end
    end

    // level interrupts, per source and combined
    assign alarm_irq = status[STAT_ALARM_BIT] & irq_en[STAT_ALARM_BIT];
    assign tick_irq = status[STAT_TICK_BIT] & irq_en[STAT_TICK_BIT];
    assign irq = alarm_irq | tick_irq;

    // ---- calibration output: 32 source edges per half period gives
    // 512 Hz from a 32.768 kHz source; other sources scale with it
    always_ff @(posedge aclk) begin
        if (!aresetn || !cal_en) begin
            cal_cnt <= '0;
            cal_out <= 1'b0;
        end else if (slow_tick) begin
            cal_cnt <= cal_cnt + 1'b1;
            if (cal_cnt == CAL_W'(CAL_HALF - 1)) cal_out <= ~cal_out;
        end
    end

    // ---- checks
    presc_down_a: assert property (@(posedge aclk) disable iff (!aresetn)
        run && slow_tick && divider != '0 && !wr_reload |=> divider == $past(divider) - 1'b1)
        else $error("prescaler did not count down on a source edge");

    // a load in the tick cycle wins, so the advance is only checked without one
    presc_reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
        presc_tick && !wr_count |=> divider == reload && counter == $past(counter) + 1'b1)
        else $error("terminal count did not reload or advance the counter");

    reload_reset_a: assert property (@(posedge aclk)
        !aresetn |=> reload == RELOAD_RST && divider == RELOAD_RST)
        else $error("prescaler reset value wrong");

    count_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_count && w_strb_q == 4'hf |=> counter == $past(w_data_q))
        else $error("counter load lost");

    run_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
        run |=> run)
        else $error("counter stopped after start");

    alarm_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        cnt_upd && counter == compare |=> status[STAT_ALARM_BIT])
        else $error("match did not raise alarm flag");

    flag_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
        status[STAT_TICK_BIT] && !clr_mask[STAT_TICK_BIT] |=> status[STAT_TICK_BIT])
        else $error("periodic flag dropped without a clear");

    tick_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        presc_tick |=> status[STAT_TICK_BIT])
        else $error("tick did not set periodic flag");

    irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(status[STAT_ALARM_BIT]) && irq_en[STAT_ALARM_BIT] |-> alarm_irq && irq)
        else $error("enabled alarm flag did not raise the interrupt");

    cal_toggle_a: assert property (@(posedge aclk) disable iff (!aresetn)
        cal_en && slow_tick && cal_cnt == 5'h1f |=> $changed(cal_out))
        else $error("calibration output missed its half period");

    bkp_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_bkp |-> bkp_wr_idx < 6'(BKP_WORDS))
        else $error("backup write outside the store");

    rd_latency_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
        else $error("read answer not two cycles after address");

    cov_alarm_c: cover property (@(posedge aclk) disable iff (!aresetn) alarm_ev);
    cov_tick_c: cover property (@(posedge aclk) disable iff (!aresetn) presc_tick);
    cov_bkp_c: cover property (@(posedge aclk) disable iff (!aresetn) wr_bkp);
    cov_setclr_c: cover property (@(posedge aclk) disable iff (!aresetn)
        presc_tick && clr_mask[STAT_TICK_BIT]);
endmodule : rtc_core

// ==== dv/rtc_core_test.sv ====
// register-level bench for the real-time counter and backup store
`timescale 1ns/100ps
module rtc_core_test;
    import rtc_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic lse = 1'b0, lsi = 1'b0, hse = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, cal_out, alarm_irq, tick_irq, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic cal_prev;
    int fail_count = 0, comparisons = 0, toggles = 0;

    rtc_core rtc_core_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .lse_pin(lse), .lsi_pin(lsi), .hse_pin(hse), .cal_out(cal_out),
        .alarm_irq(alarm_irq), .tick_irq(tick_irq), .irq(irq));

    // 125 MHz clock
    initial begin
        forever #4 aclk = ~aclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // both channels offered together, each dropped at its own handshake
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        chk(bresp, er);
    endtask : wr

    // rready stays high, so the answer is taken at the edge rvalid is seen
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        chk(rdata, ed);
        chk(rresp, er);
    endtask : rd

    // n source edges on pin s, phases of 4 cycles to clear the synchronisers
    task automatic edges(input int s, input int n);
        repeat (n) begin
            {hse, lsi, lse} <= 3'h1 << s;
            repeat (4) @(posedge aclk);
            {hse, lsi, lse} <= 3'h0;
            repeat (4) @(posedge aclk);
            if (cal_out !== cal_prev) toggles++;
            cal_prev = cal_out;
        end
    endtask : edges

    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask : do_reset

    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    // about 5000 cycles of work; a hang is cut well beyond that
    initial begin
        repeat (30000) @(posedge aclk);
        fail_count++;
        final_report();
    end

    initial begin
        do_reset();
        rd(REG_RELOAD, 32'h00007fff, RESP_OKAY);
        rd(REG_DIVIDER, 32'h00007fff, RESP_OKAY);
        rd(REG_COUNT, 32'h0, RESP_OKAY);
        rd(REG_STATUS, 32'h0, RESP_OKAY);
        // backup words: first, last, and one past the end
        wr(REG_BACKUP, 32'hffffa5c3, RESP_OKAY);
        wr(REG_BACKUP + 8'ha4, 32'h00001234, RESP_OKAY);
        rd(REG_BACKUP, 32'h0000a5c3, RESP_OKAY);
        wr(REG_BACKUP + 8'ha8, 32'h0000ffff, RESP_DECERR);
        rd(REG_BACKUP + 8'ha8, 32'h0, RESP_DECERR);
        $display("test backup done");
        // ratio reload plus one: 8 edges give two ticks, alarm when count reaches 2
        wr(REG_RELOAD, 32'h3, RESP_OKAY);
        wr(REG_COMPARE, 32'h2, RESP_OKAY);
        wr(REG_IRQ_EN, 32'h3, RESP_OKAY);
        wr(REG_CTRL, 32'h4, RESP_OKAY);
        cal_prev = cal_out;
        edges(0, 8);
        rd(REG_COUNT, 32'h2, RESP_OKAY);
        rd(REG_STATUS, 32'h3, RESP_OKAY);
        chk({alarm_irq, tick_irq, irq, cal_out}, 4'he);
        wr(REG_IRQ_EN, 32'h1, RESP_OKAY);
        chk({alarm_irq, tick_irq, irq}, 3'h5);
        wr(REG_IRQ_CLR, 32'h3, RESP_OKAY);
        rd(REG_STATUS, 32'h0, RESP_OKAY);
        chk(irq, 1'b0);
        $display("test tick and alarm done");
        // run cannot be cleared; other sources ignored; low-power osc; fast clock over 128
        wr(REG_CTRL, 32'h0, RESP_OKAY);
        edges(0, 4);
        rd(REG_COUNT, 32'h3, RESP_OKAY);
        wr(REG_CTRL, 32'h5, RESP_OKAY);
        edges(0, 4);
        edges(1, 4);
        rd(REG_COUNT, 32'h4, RESP_OKAY);
        wr(REG_CTRL, 32'h6, RESP_OKAY);
        edges(2, 512);
        rd(REG_COUNT, 32'h5, RESP_OKAY);
        $display("test sources done");
        // calibration output toggles every 32 source edges
        wr(REG_CTRL, 32'hc, RESP_OKAY);
        toggles = 0;
        edges(0, 64);
        chk(toggles, 2);
        rd(REG_COUNT, 32'd21, RESP_OKAY);
        // a load that lands on the compare value raises the alarm
        wr(REG_IRQ_CLR, 32'h2, RESP_OKAY);
        wr(REG_COMPARE, 32'hfedc1234, RESP_OKAY);
        wr(REG_COUNT, 32'hfedc1234, RESP_OKAY);
        rd(REG_COUNT, 32'hfedc1234, RESP_OKAY);
        rd(REG_STATUS, 32'h1, RESP_OKAY);
        $display("test calibration and load done");
        // backup words survive reset, counter does not
        do_reset();
        rd(REG_BACKUP, 32'h0000a5c3, RESP_OKAY);
        rd(REG_BACKUP + 8'ha4, 32'h00001234, RESP_OKAY);
        rd(REG_COUNT, 32'h0, RESP_OKAY);
        $display("test retention done");
        final_report();
    end
endmodule : rtc_core_test
